// ### rtl/sfs_flash_seq.sv
// Serial flash command sequencer: quad page program, secure area, deep sleep
`timescale 1ns/1ps
module sfs_flash_seq
  import sfs_pkg::*;
#(
  parameter int PAGE_PROG_CYCLES = sfs_pkg::PAGE_PROGRAM_CYCLES,
  parameter int SECTOR_ERASE_CYCLES_P = sfs_pkg::SECTOR_ERASE_CYCLES,
  // Arbitrary signature value
  parameter logic [7:0] SIGNATURE = 8'h5A
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic csN,
  input wire logic [3:0] dataLinesQuadIn,
  output logic io1Out,
  output logic io1OeN,
  input wire sfs_pkg::sfs_cfg_t cfg,
  output sfs_pkg::sfs_status_t status,
  output sfs_pkg::sfs_pgreq_t pgReq,
  input wire logic [7:0] pageBufRdIdx,
  output logic [7:0] pageBufRdData
);
  import sfs_pkg::*;

  typedef struct packed {
    logic [1:0] csDly;
    logic togDly;
    logic active;
    logic [7:0] op;
    logic [2:0] cnt;
    logic [23:0] addr;
    logic [1:0] secIdx;
    logic [8:0] wrPtr;
    logic [9:0] len;
    logic [8:0] rdPtr;
    logic fetch;
    logic fetchOk;
    logic [7:0] txData;
    logic write_enable_latch;
    sfs_busy_t busy;
    logic [31:0] timer;
    logic [1:0] engSec;
    logic [8:0] engIdx;
    logic [9:0] engLeft;
    logic engPhase;
    sfs_pwr_t pwr;
    logic [15:0] pwrTimer;
    sfs_pgreq_t pg;
  } sfs_state_t;

  sfs_state_t state_ff;
  sfs_state_t nxt_state;

  // Link side (sclk domain)
  logic linkRst;
  logic [2:0] bitCnt_ff;
  logic [2:0] byteIdx_ff;
  logic [7:0] shIn_ff;
  logic [7:0] opL_ff;
  logic [7:0] rxByte_ff;
  logic rxTog_ff;
  logic partial_ff;
  logic [7:0] txShift_ff;
  logic drive_ff;
  logic quadPh;
  logic [2:0] nxtBit;
  logic [7:0] newBits;
  logic driveOk;
  logic [1:0] gateSync;

  // Core side crossings
  logic csSync;
  logic togSync;
  logic partialSync;

  // Memory ports
  logic secWe;
  logic [SEC_MEM_AW-1:0] secWa;
  logic [7:0] secWd;
  logic [SEC_MEM_AW-1:0] secRa;
  logic [7:0] secRd;
  logic bufWe;
  logic [SEC_OFS_W-1:0] bufWa;
  logic [SEC_OFS_W-1:0] bufRa;
  logic [7:0] bufRd;

  // Chip select high holds the link counters, shifters and output driver in reset; frames start clean
  assign linkRst = !resetn || csN;
  assign quadPh = (opL_ff == OP_QUAD_INPUT_PAGE_PROGRAM) && (byteIdx_ff >= CNT_DATA_FIRST);
  assign nxtBit = bitCnt_ff + (quadPh ? QUAD_STEP : SINGLE_STEP);
  assign newBits = quadPh ? {shIn_ff[3:0], dataLinesQuadIn} : {shIn_ff[6:0], dataLinesQuadIn[0]};

  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      bitCnt_ff <= CNT_NONE;
      byteIdx_ff <= CNT_NONE;
      shIn_ff <= 8'h00;
      opL_ff <= 8'h00;
    end else begin
      bitCnt_ff <= nxtBit;
      shIn_ff <= newBits;
      if (nxtBit == CNT_NONE) begin
        if (byteIdx_ff == CNT_NONE) begin
          opL_ff <= newBits;
        end
        if (byteIdx_ff != CNT_MAX) begin
          byteIdx_ff <= byteIdx_ff + SINGLE_STEP;
        end
      end
    end
  end

  // Kept across deselect so the core can judge the byte boundary afterwards
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      rxByte_ff <= 8'h00;
      rxTog_ff <= 1'b0;
      partial_ff <= 1'b0;
    end else begin
      partial_ff <= (nxtBit != CNT_NONE);
      if (nxtBit == CNT_NONE) begin
        rxByte_ff <= newBits;
        rxTog_ff <= !rxTog_ff;
      end
    end
  end

  // gateSync[0]: not in standby, gateSync[1]: cycle running
  sfs_sync #(.W(2)) uGateSync (
    .clk(sclk),
    .rstN(resetn),
    .d({status.writeInProgress, state_ff.pwr != PWR_ON}),
    .q(gateSync)
  );

  assign driveOk =
    ((opL_ff == OP_SECURE_AREA_READ) && (byteIdx_ff >= LINK_READ_START) && !gateSync[0]) ||
    ((opL_ff == OP_WAKE_SIGNATURE) && (byteIdx_ff >= LINK_SIG_START) && !gateSync[1]);

  // Output shifts on falling edges; txData is held steady a full byte ahead
  always_ff @(negedge sclk or posedge linkRst) begin
    if (linkRst) begin
      txShift_ff <= 8'h00;
      drive_ff <= 1'b0;
    end else if (bitCnt_ff == CNT_NONE && driveOk) begin
      txShift_ff <= state_ff.txData;
      drive_ff <= 1'b1;
    end else begin
      txShift_ff <= {txShift_ff[6:0], 1'b0};
    end
  end

  assign io1Out = txShift_ff[7];
  assign io1OeN = !drive_ff;

  sfs_sync #(.W(3)) uCoreSync (
    .clk(clk),
    .rstN(resetn),
    .d({csN, rxTog_ff, partial_ff}),
    .q({csSync, togSync, partialSync})
  );

  sfs_mem #(.AW(SEC_MEM_AW), .W(8)) uSecMem (
    .clk(clk),
    .resetn(resetn),
    .we(secWe),
    .wa(secWa),
    .wd(secWd),
    .ra(secRa),
    .rd(secRd)
  );

  sfs_mem #(.AW(SEC_OFS_W), .W(8)) uPageBuf (
    .clk(clk),
    .resetn(resetn),
    .we(bufWe),
    .wa(bufWa),
    .wd(rxByte_ff),
    .ra(bufRa),
    .rd(bufRd)
  );

  always_comb begin
    logic bytePulse;
    logic csRise;
    logic csFall;
    logic aligned;
    logic idle;
    logic on;
    logic [23:0] na;
    logic [9:0] limit;
    nxt_state = state_ff;
    bytePulse = togSync ^ state_ff.togDly;
    csRise = state_ff.csDly[0] && !state_ff.csDly[1];
    csFall = !state_ff.csDly[0] && state_ff.csDly[1];
    aligned = !partialSync;
    idle = (state_ff.busy == BZ_IDLE);
    on = (state_ff.pwr == PWR_ON);
    na = {state_ff.addr[15:0], rxByte_ff};
    limit = cfg.dataPageSize ? SEC_BYTES : PAGE_BYTES;
    secWe = 1'b0;
    secWa = {state_ff.engSec, state_ff.engIdx};
    secWd = ERASED_BYTE;
    secRa = {state_ff.engSec, state_ff.engIdx};
    bufWe = 1'b0;
    bufWa = state_ff.wrPtr;
    bufRa = {1'b0, pageBufRdIdx};
    nxt_state.csDly = {state_ff.csDly[0], csSync};
    nxt_state.togDly = togSync;
    nxt_state.pg.start = 1'b0;
    nxt_state.fetch = 1'b0;

    if (state_ff.fetch) begin
      nxt_state.txData = state_ff.fetchOk ? secRd : ERASED_BYTE;
    end

    // Power state timing
    case (state_ff.pwr)
      PWR_ENTER: begin
        if (state_ff.pwrTimer == 16'h0000) begin
          nxt_state.pwr = PWR_DOWN;
        end else begin
          nxt_state.pwrTimer = state_ff.pwrTimer - 16'h0001;
        end
      end
      PWR_WAKE: begin
        if (state_ff.pwrTimer == 16'h0000) begin
          nxt_state.pwr = PWR_ON;
        end else begin
          nxt_state.pwrTimer = state_ff.pwrTimer - 16'h0001;
        end
      end
      default: begin
      end
    endcase

    // Self-timed cycle; the secure-area copy runs inside the timed window
    if (!idle) begin
      if (state_ff.timer != 32'h0) begin
        nxt_state.timer = state_ff.timer - 32'h1;
      end
      if (state_ff.engLeft != 10'h000) begin
        if (!state_ff.engPhase) begin
          if (!(state_ff.active && state_ff.op == OP_SECURE_AREA_READ)) begin
            bufRa = state_ff.engIdx;
            nxt_state.engPhase = 1'b1;
          end
        end else begin
          secWe = 1'b1;
          // Programming only clears bits
          secWd = (state_ff.busy == BZ_SEC_ERASE) ? ERASED_BYTE : (secRd & bufRd);
          nxt_state.engIdx = state_ff.engIdx + 9'h001;
          nxt_state.engLeft = state_ff.engLeft - 10'h001;
          nxt_state.engPhase = 1'b0;
        end
      end else if (state_ff.timer == 32'h0) begin
        nxt_state.busy = BZ_IDLE;
        nxt_state.write_enable_latch = 1'b0;
      end
    end

    if (csFall) begin
      nxt_state.active = 1'b1;
      nxt_state.cnt = CNT_NONE;
    end

    // Incoming byte
    if (bytePulse && state_ff.active) begin
      if (state_ff.cnt != CNT_MAX) begin
        nxt_state.cnt = state_ff.cnt + SINGLE_STEP;
      end
      if (state_ff.cnt == CNT_NONE) begin
        nxt_state.op = rxByte_ff;
        if (rxByte_ff == OP_WAKE_SIGNATURE) begin
          nxt_state.txData = SIGNATURE;
        end
      end else if (state_ff.cnt <= CNT_ADDR_LAST) begin
        nxt_state.addr = na;
      end
      if (state_ff.cnt == CNT_ADDR_LAST) begin
        nxt_state.secIdx = secIdxOf(na);
        nxt_state.rdPtr = na[SEC_OFS_W-1:0];
        nxt_state.len = 10'h000;
        nxt_state.wrPtr = (state_ff.op == OP_QUAD_INPUT_PAGE_PROGRAM) ?
          {1'b0, na[PAGE_OFS_W-1:0]} : na[SEC_OFS_W-1:0];
      end
      // Prefetch one byte ahead of the link
      if (state_ff.cnt >= CNT_ADDR_LAST && state_ff.op == OP_SECURE_AREA_READ) begin
        secRa = {nxt_state.secIdx, nxt_state.rdPtr};
        nxt_state.fetch = 1'b1;
        nxt_state.fetchOk = secAddrOk(nxt_state.addr);
        nxt_state.rdPtr = nxt_state.rdPtr + 9'h001;
      end
      if (state_ff.cnt >= CNT_DATA_FIRST && idle) begin
        if (state_ff.op == OP_QUAD_INPUT_PAGE_PROGRAM) begin
          bufWe = 1'b1;
          bufWa = {1'b0, state_ff.wrPtr[PAGE_OFS_W-1:0]};
          nxt_state.wrPtr = {1'b0, state_ff.wrPtr[PAGE_OFS_W-1:0] + 8'h01};
          if (state_ff.len != PAGE_BYTES) begin
            nxt_state.len = state_ff.len + 10'h001;
          end
        end else if (state_ff.op == OP_SECURE_AREA_PROGRAM && state_ff.len != limit) begin
          bufWe = 1'b1;
          nxt_state.wrPtr = state_ff.wrPtr + 9'h001;
          nxt_state.len = state_ff.len + 10'h001;
        end
      end
    end

    // Deselect: decide on the frame
    if (csRise && state_ff.active) begin
      nxt_state.active = 1'b0;
      case (nxt_state.op)
        OP_SET_WRITE_LATCH: begin
          if (nxt_state.cnt == CNT_OP_ONLY && aligned && on) begin
            nxt_state.write_enable_latch = 1'b1;
          end
        end
        OP_DEEP_SLEEP: begin
          if (nxt_state.cnt == CNT_OP_ONLY && aligned && on && idle) begin
            nxt_state.pwr = PWR_ENTER;
            nxt_state.pwrTimer = 16'(SLEEP_ENTRY_CYCLES);
          end
        end
        OP_WAKE_SIGNATURE: begin
          // Not sleeping: standby is immediate, nothing to do
          if (idle && !on &&
              ((nxt_state.cnt == CNT_OP_ONLY && aligned) || nxt_state.cnt >= CNT_SIG_MIN)) begin
            nxt_state.pwr = PWR_WAKE;
            nxt_state.pwrTimer = 16'(WAKE_RECOVERY_CYCLES);
          end
        end
        OP_QUAD_INPUT_PAGE_PROGRAM: begin
          if (on && idle && state_ff.write_enable_latch && cfg.quadIoEnable && !cfg.writeProtect &&
              nxt_state.cnt >= CNT_PROG_MIN && aligned) begin
            nxt_state.busy = BZ_PAGE;
            nxt_state.timer = 32'(PAGE_PROG_CYCLES);
            nxt_state.pg.start = 1'b1;
            nxt_state.pg.addr = nxt_state.addr;
            nxt_state.pg.first = nxt_state.wrPtr[PAGE_OFS_W-1:0] - nxt_state.len[PAGE_OFS_W-1:0];
            nxt_state.pg.len = nxt_state.len;
          end
        end
        OP_SECURE_AREA_PROGRAM: begin
          if (on && idle && state_ff.write_enable_latch && secAddrOk(nxt_state.addr) &&
              !cfg.secureAreaLockBits[nxt_state.secIdx - 2'h1] &&
              nxt_state.cnt >= CNT_PROG_MIN && aligned) begin
            nxt_state.busy = BZ_SEC_PROG;
            nxt_state.timer = 32'(PAGE_PROG_CYCLES);
            nxt_state.engSec = nxt_state.secIdx;
            nxt_state.engIdx = nxt_state.addr[SEC_OFS_W-1:0];
            nxt_state.engLeft = nxt_state.len;
            nxt_state.engPhase = 1'b0;
          end
        end
        OP_SECURE_AREA_ERASE: begin
          if (on && idle && state_ff.write_enable_latch && secAddrOk(nxt_state.addr) &&
              !cfg.secureAreaLockBits[nxt_state.secIdx - 2'h1] &&
              nxt_state.cnt == CNT_ERASE && aligned) begin
            nxt_state.busy = BZ_SEC_ERASE;
            nxt_state.timer = 32'(SECTOR_ERASE_CYCLES_P);
            nxt_state.engSec = nxt_state.secIdx;
            nxt_state.engIdx = 9'h000;
            nxt_state.engLeft = SEC_BYTES;
            nxt_state.engPhase = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Power-up lands in standby
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Matches the synchroniser's reset level, so no false select edge follows reset
      state_ff <= '{pwr: PWR_ON, busy: BZ_IDLE, default: '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign status.writeInProgress = (state_ff.busy != BZ_IDLE);
  assign status.writeEnableLatch = state_ff.write_enable_latch;
  assign status.deepSleep = (state_ff.pwr == PWR_DOWN);
  assign pgReq = state_ff.pg;
  assign pageBufRdData = bufRd;

endmodule : sfs_flash_seq

// ### rtl/sfs_mem.sv
// Simple dual-port byte memory with registered read data
`timescale 1ns/1ps
module sfs_mem #(
  parameter int AW = 9,
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [W-1:0] wd,
  input wire logic [AW-1:0] ra,
  output logic [W-1:0] rd
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd <= '0;
    end else begin
      rd <= mem[ra];
    end
  end
endmodule : sfs_mem

// ### rtl/sfs_pkg.sv
// Shared constants, types and helpers of the serial flash command sequencer
package sfs_pkg;

  localparam int CLK_PERIOD_NS = 40;

  // Opcodes handled by this block
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_QUAD_INPUT_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] OP_SECURE_AREA_ERASE = 8'h44;
  localparam logic [7:0] OP_SECURE_AREA_PROGRAM = 8'h42;
  localparam logic [7:0] OP_SECURE_AREA_READ = 8'h48;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_SIGNATURE = 8'hAB;

  // Times in ns, counts in clk cycles (rounded up)
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int WAKE_RECOVERY_DELAY_NS = 8000;
  localparam int PAGE_PROGRAM_TIME_NS = 2000000;
  localparam int SECTOR_ERASE_TIME_NS = 100000000;
  localparam int SLEEP_ENTRY_CYCLES = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_RECOVERY_CYCLES =
    (WAKE_RECOVERY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_PROGRAM_CYCLES = (PAGE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SECTOR_ERASE_CYCLES = (SECTOR_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Frame byte positions (bytes received so far, saturating) and counter steps
  localparam logic [2:0] CNT_NONE = 3'h0;
  localparam logic [2:0] CNT_OP_ONLY = 3'h1;
  localparam logic [2:0] CNT_ADDR_LAST = 3'h3;
  localparam logic [2:0] CNT_ERASE = 3'h4;
  localparam logic [2:0] CNT_DATA_FIRST = 3'h4;
  localparam logic [2:0] CNT_PROG_MIN = 3'h5;
  localparam logic [2:0] CNT_SIG_MIN = 3'h4;
  localparam logic [2:0] CNT_MAX = 3'h7;
  localparam logic [2:0] LINK_READ_START = 3'h5;
  localparam logic [2:0] LINK_SIG_START = 3'h4;
  localparam logic [2:0] QUAD_STEP = 3'h4;
  localparam logic [2:0] SINGLE_STEP = 3'h1;

  // Secure area address layout
  localparam int SEC_BANK_MSB = 23;
  localparam int SEC_BANK_LSB = 16;
  localparam int SEC_SEL_MSB = 15;
  localparam int SEC_SEL_LSB = 12;
  localparam int SEC_PAD_MSB = 11;
  localparam int SEC_PAD_LSB = 9;
  localparam int SEC_OFS_W = 9;
  localparam int SEC_MEM_AW = 11;
  localparam int PAGE_OFS_W = 8;
  localparam logic [7:0] SEC_BANK = 8'h00;
  localparam logic [2:0] SEC_PAD = 3'h0;
  localparam logic [3:0] SEC_SEL_1 = 4'h1;
  localparam logic [3:0] SEC_SEL_2 = 4'h2;
  localparam logic [3:0] SEC_SEL_3 = 4'h3;
  localparam logic [9:0] PAGE_BYTES = 10'h100;
  localparam logic [9:0] SEC_BYTES = 10'h200;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  typedef enum logic [1:0] {
    PWR_ON = 2'b00,
    PWR_ENTER = 2'b01,
    PWR_DOWN = 2'b10,
    PWR_WAKE = 2'b11
  } sfs_pwr_t;

  typedef enum logic [1:0] {
    BZ_IDLE = 2'b00,
    BZ_PAGE = 2'b01,
    BZ_SEC_PROG = 2'b10,
    BZ_SEC_ERASE = 2'b11
  } sfs_busy_t;

  typedef struct packed {
    logic quadIoEnable;
    logic dataPageSize;
    logic writeProtect;
    logic [2:0] secureAreaLockBits;
  } sfs_cfg_t;

  typedef struct packed {
    logic writeInProgress;
    logic writeEnableLatch;
    logic deepSleep;
  } sfs_status_t;

  typedef struct packed {
    logic start;
    logic [23:0] addr;
    logic [7:0] first;
    logic [9:0] len;
  } sfs_pgreq_t;

  function automatic logic secAddrOk(input logic [23:0] a);
    logic [3:0] sel;
    sel = a[SEC_SEL_MSB:SEC_SEL_LSB];
    secAddrOk = (a[SEC_BANK_MSB:SEC_BANK_LSB] == SEC_BANK) &&
                (a[SEC_PAD_MSB:SEC_PAD_LSB] == SEC_PAD) &&
                (sel == SEC_SEL_1 || sel == SEC_SEL_2 || sel == SEC_SEL_3);
  endfunction : secAddrOk

  function automatic logic [1:0] secIdxOf(input logic [23:0] a);
    secIdxOf = a[SEC_SEL_LSB+1:SEC_SEL_LSB];
  endfunction : secIdxOf

endpackage : sfs_pkg

// ### rtl/sfs_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module sfs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : sfs_sync

// ### test/sfs_flash_seq_props.sv
// Port checker for the flash command sequencer
`timescale 1ns/1ps
module sfs_flash_seq_props #(
  parameter int PAGE_PROG_CYCLES = 1200,
  parameter int SECTOR_ERASE_CYCLES_P = 1200
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic csN,
  input wire logic [3:0] dataLinesQuadIn,
  input wire logic io1Out,
  input wire logic io1OeN,
  input wire sfs_pkg::sfs_cfg_t cfg,
  input wire sfs_pkg::sfs_status_t status,
  input wire sfs_pkg::sfs_pgreq_t pgReq,
  input wire logic [7:0] pageBufRdIdx,
  input wire logic [7:0] pageBufRdData
);
  import sfs_pkg::*;
  logic [31:0] busyCnt_ff;
  logic [31:0] nxt_busyCnt;
  logic lenOk;
  // Busy length is counted, a repetition this long would stall the tools
  assign nxt_busyCnt = status.writeInProgress ? busyCnt_ff + 32'h1 : 32'h0;
  assign lenOk = (busyCnt_ff >= PAGE_PROG_CYCLES - 1 && busyCnt_ff <= PAGE_PROG_CYCLES + 3) ||
    (busyCnt_ff >= SECTOR_ERASE_CYCLES_P - 1 && busyCnt_ff <= SECTOR_ERASE_CYCLES_P + 3);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) busyCnt_ff <= 32'h0;
    else busyCnt_ff <= nxt_busyCnt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_oe_off_desel: assert property (csN |-> io1OeN)
    else $error("data line driven while deselected");
  a_busy_needs_latch: assert property ($rose(status.writeInProgress) |-> status.writeEnableLatch)
    else $error("cycle started without write latch");
  a_done_clears_latch: assert property ($fell(status.writeInProgress) |-> !status.writeEnableLatch)
    else $error("latch not cleared at cycle end");
  a_quad_enable_ok: assert property (pgReq.start |-> cfg.quadIoEnable && !cfg.writeProtect)
    else $error("quad program accepted while disabled");
  a_start_busy: assert property (pgReq.start |-> ##[0:2] status.writeInProgress)
    else $error("quad program without busy flag");
  a_len_in_page: assert property (pgReq.start |-> pgReq.len inside {[10'h1:10'h100]})
    else $error("kept length outside one page");
  a_busy_length: assert property ($fell(status.writeInProgress) |-> lenOk)
    else $error("busy time off");
  a_no_prog_asleep: assert property ($rose(status.writeInProgress) |-> !$past(status.deepSleep))
    else $error("cycle started in deep sleep");
  a_sleep_after_desel: assert property ($rose(status.deepSleep) |-> $past(csN, 8))
    else $error("deep sleep without deselect delay");
  a_wake_on_desel: assert property ($fell(status.deepSleep) |-> $past(csN, 2))
    else $error("wake without deselect");
  a_reset_standby: assert property ($rose(resetn) |-> !status.deepSleep)
    else $error("reset left deep sleep");
  c_quad: cover property (pgReq.start);
  c_wake: cover property ($fell(status.deepSleep));
  c_done: cover property ($fell(status.writeInProgress));
  c_drive: cover property (!io1OeN);
endmodule : sfs_flash_seq_props

bind sfs_flash_seq sfs_flash_seq_props #(
  .PAGE_PROG_CYCLES(PAGE_PROG_CYCLES),
  .SECTOR_ERASE_CYCLES_P(SECTOR_ERASE_CYCLES_P)
) u_props (
  .clk(clk), .resetn(resetn), .sclk(sclk), .csN(csN), .dataLinesQuadIn(dataLinesQuadIn),
  .io1Out(io1Out), .io1OeN(io1OeN), .cfg(cfg), .status(status), .pgReq(pgReq),
  .pageBufRdIdx(pageBufRdIdx), .pageBufRdData(pageBufRdData)
);

// ### test/sfs_host_model.sv
// Serial host model, mode 0, clock runs only inside frames
`timescale 1ns/1ps
module sfs_host_model (
  output logic sclk,
  output logic csN,
  output logic [3:0] dataLinesQuadIn,
  input wire logic io1Level
);
  initial begin
    sclk = 1'h0;
    csN = 1'h1;
    dataLinesQuadIn = 4'hA;
  end
  task automatic sel();
    csN = 1'h0;
    #32;
  endtask : sel
  // Released lines flip so that a stale level is never mistaken for data
  task automatic desel();
    #32 csN = 1'h1;
    dataLinesQuadIn = ~dataLinesQuadIn;
    #400;
  endtask : desel
  task automatic xfer(input logic [7:0] b, input bit quad, input int nb, output logic [7:0] r);
    int n;
    n = quad ? 2 : nb;
    r = 8'h0;
    for (int i = 0; i < n; i++) begin
      if (quad) dataLinesQuadIn = (i == 0) ? b[7:4] : b[3:0];
      else dataLinesQuadIn = {~dataLinesQuadIn[3:1], b[7 - i]};
      #32 sclk = 1'h1;
      r = {r[6:0], io1Level};
      #32 sclk = 1'h0;
    end
  endtask : xfer
endmodule : sfs_host_model

// ### test/tb_top.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module tb_top;
  import sfs_pkg::*;
  localparam logic [7:0] SIG = 8'hC3; // Arbitrary signature value
  logic clk;
  logic resetn;
  logic sclk;
  logic csN;
  logic [3:0] dataLinesQuadIn;
  logic io1Out;
  logic io1OeN;
  sfs_cfg_t cfg;
  sfs_status_t status;
  sfs_pgreq_t pgReq;
  logic [7:0] pageBufRdIdx;
  logic [7:0] pageBufRdData;
  logic [7:0] rb;
  int error_cnt;
  int tests_run;

  sfs_flash_seq #(.PAGE_PROG_CYCLES(1200), .SECTOR_ERASE_CYCLES_P(1200), .SIGNATURE(SIG)) u_dut (
    .clk(clk), .resetn(resetn), .sclk(sclk), .csN(csN), .dataLinesQuadIn(dataLinesQuadIn),
    .io1Out(io1Out), .io1OeN(io1OeN), .cfg(cfg), .status(status), .pgReq(pgReq),
    .pageBufRdIdx(pageBufRdIdx), .pageBufRdData(pageBufRdData));
  sfs_host_model u_host (.sclk(sclk), .csN(csN), .dataLinesQuadIn(dataLinesQuadIn),
    .io1Level(io1OeN === 1'h0 ? io1Out : dataLinesQuadIn[1]));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %0h, expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic waitWip(input logic v);
    int n;
    n = 0;
    while (status.writeInProgress !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      error_cnt++;
      stop_test();
    end
  endtask : waitWip

  task automatic send(input logic [7:0] q[$], input int qf = 99, input int lb = 8);
    u_host.sel();
    foreach (q[i]) u_host.xfer(q[i], i >= qf, (i == q.size() - 1) ? lb : 8, rb);
  endtask : send

  task automatic cmd(input logic [7:0] q[$], input int qf = 99, input int lb = 8);
    send(q, qf, lb);
    u_host.desel();
  endtask : cmd

  task automatic rdChk(input logic [7:0] exp);
    u_host.xfer(8'hFF, 1'h0, 8, rb);
    chk(rb, exp);
  endtask : rdChk

  task automatic prog(input logic [23:0] a, input logic [7:0] d);
    cmd('{OP_SET_WRITE_LATCH});
    cmd('{OP_SECURE_AREA_PROGRAM, a[23:16], a[15:8], a[7:0], d});
    chk(status.writeInProgress, 1'h1);
    waitWip(1'h0);
  endtask : prog

  task automatic s_quad();
    cmd('{OP_SET_WRITE_LATCH});
    cmd('{OP_QUAD_INPUT_PAGE_PROGRAM, 8'h00, 8'h01, 8'hFE, 8'h11}, 4);
    chk(status.writeInProgress, 1'h0);
    @(posedge clk) cfg.quadIoEnable <= 1'h1;
    cfg.writeProtect <= 1'h1;
    cmd('{OP_QUAD_INPUT_PAGE_PROGRAM, 8'h00, 8'h01, 8'hFE, 8'h11}, 4);
    chk(status.writeInProgress, 1'h0);
    @(posedge clk) cfg.writeProtect <= 1'h0;
    cmd('{OP_QUAD_INPUT_PAGE_PROGRAM, 8'h00, 8'h01, 8'hFE, 8'h11, 8'h22, 8'h33}, 4);
    chk(pgReq.addr, 24'h0001FE);
    chk(pgReq.first, 8'hFE);
    chk(pgReq.len, 10'h3);
    waitWip(1'h0);
    chk(status.writeEnableLatch, 1'h0);
    // Offsets FE, FF, 00 show the wrap inside the page
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) pageBufRdIdx <= 8'hFE + 8'(i);
      repeat (2) @(posedge clk);
      #1;
      chk(pageBufRdData, 8'h11 * (i + 1));
    end
  endtask : s_quad

  task automatic s_secure();
    cmd('{OP_SECURE_AREA_ERASE, 8'h00, 8'h10, 8'h00});
    chk(status.writeInProgress, 1'h0);
    cmd('{OP_SET_WRITE_LATCH});
    cmd('{OP_SECURE_AREA_ERASE, 8'h00, 8'h10, 8'h00}, 99, 7);
    chk(status.writeInProgress, 1'h0);
    cmd('{OP_SECURE_AREA_ERASE, 8'h00, 8'h10, 8'h00});
    chk(status.writeInProgress, 1'h1);
    cmd('{OP_WAKE_SIGNATURE, 8'h00, 8'h00, 8'h00, 8'h00});
    chk(status.writeInProgress, 1'h1);
    waitWip(1'h0);
    @(posedge clk) cfg.secureAreaLockBits <= 3'h1;
    cmd('{OP_SET_WRITE_LATCH});
    cmd('{OP_SECURE_AREA_PROGRAM, 8'h00, 8'h10, 8'h05, 8'h00});
    chk(status.writeInProgress, 1'h0);
    cmd('{OP_SECURE_AREA_ERASE, 8'h00, 8'h10, 8'h00});
    chk(status.writeInProgress, 1'h0);
    @(posedge clk) cfg.secureAreaLockBits <= 3'h0;
    prog(24'h0011FF, 8'h22);
    prog(24'h001000, 8'h11);
    send('{OP_SECURE_AREA_READ, 8'h00, 8'h11, 8'hFF, 8'h00});
    rdChk(8'h22);
    rdChk(8'h11);
    u_host.desel();
  endtask : s_secure

  task automatic s_sleep();
    cmd('{OP_WAKE_SIGNATURE});
    cmd('{OP_SET_WRITE_LATCH});
    chk(status.writeEnableLatch, 1'h1);
    cmd('{OP_DEEP_SLEEP});
    chk(status.deepSleep, 1'h0);
    repeat (80) @(posedge clk);
    chk(status.deepSleep, 1'h1);
    cmd('{OP_SECURE_AREA_ERASE, 8'h00, 8'h20, 8'h00});
    chk(status.writeInProgress, 1'h0);
    send('{OP_WAKE_SIGNATURE, 8'h00, 8'h00, 8'h00});
    rdChk(SIG);
    rdChk(SIG);
    chk(io1OeN, 1'h0);
    u_host.desel();
    chk(io1OeN, 1'h1);
    chk(status.deepSleep, 1'h0);
    cmd('{OP_SECURE_AREA_ERASE, 8'h00, 8'h20, 8'h00});
    chk(status.writeInProgress, 1'h0);
    repeat (220) @(posedge clk);
    cmd('{OP_SECURE_AREA_ERASE, 8'h00, 8'h20, 8'h00});
    chk(status.writeInProgress, 1'h1);
    waitWip(1'h0);
  endtask : s_sleep

  initial begin
    resetn = 1'h0;
    cfg = '0;
    pageBufRdIdx = 8'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    repeat (4) @(posedge clk);
    chk(status, 3'h0);
    chk(io1OeN, 1'h1);
    s_quad();
    s_secure();
    s_sleep();
    stop_test();
  end

  // Cut short a hang well beyond the run length
  initial begin
    #3000000;
    error_cnt++;
    stop_test();
  end
endmodule : tb_top
